// *** rtl/vfac_pkg.sv ***
// shared constants for the vf allocation command link
package vfac_pkg;
    localparam int        NUM_PF_DEF     = 4;
    // command codes carried in the first byte of a request
    localparam logic [7:0] CMD_GET_PT    = 8'h34;
    localparam logic [7:0] CMD_QUERY_VF  = 8'h35;
    localparam logic [7:0] CMD_SET_VF    = 8'h36;
    // response codes carried in the first byte of a response
    localparam logic [7:0] RSP_FLAG      = 8'h80;
    localparam logic [7:0] RSP_GET_PT    = 8'hB4;
    localparam logic [7:0] RSP_QUERY_VF  = 8'hB5;
    localparam logic [7:0] RSP_SET_VF    = 8'hB6;
    // completion and reason values
    localparam logic [15:0] CODE_OK      = 16'h0000;
    localparam logic [15:0] CODE_FAIL    = 16'h0001;
    localparam logic [15:0] CODE_UNSUPP  = 16'h0002;
    localparam logic [15:0] REASON_NONE  = 16'h0000;
    localparam logic [15:0] REASON_PARAM = 16'h0002;
    localparam logic [15:0] REASON_LEN   = 16'h0003;
    localparam logic [15:0] REASON_CMD   = 16'h7FFF;
    // response layout: type, code hi, code lo, reason hi, reason lo
    localparam logic [7:0] RSP_HDR_LEN   = 8'h05;
    localparam logic [7:0] PT_DATA_LEN   = 8'h04;
    localparam logic [7:0] PT_STATUS_IDX = 8'h07;
    localparam logic [7:0] PT_CAP_IDX    = 8'h08;
    // pass-through path bit positions
    localparam int        PT_NET_BIT     = 0;
    localparam int        PT_HOST_BIT    = 1;
    localparam int        PT_EMB_BIT     = 2;
    localparam int        PT_W           = 3;
    localparam logic [4:0] PT_RSVD       = 5'h00;
    localparam logic [7:0] VF_RESET_DEF  = 8'h00;
endpackage

// *** rtl/vfac_if.sv ***
// byte-stream link between management controller and device
`timescale 1ns/1ps
`default_nettype none
interface vfac_if;
    logic       cmd_valid;
    logic       cmd_ready;
    logic [7:0] cmd_data;
    logic       cmd_last;
    logic       rsp_valid;
    logic       rsp_ready;
    logic [7:0] rsp_data;
    logic       rsp_last;

    modport dev (
        input  cmd_valid, cmd_data, cmd_last, rsp_ready,
        output cmd_ready, rsp_valid, rsp_data, rsp_last
    );
    modport mc (
        output cmd_valid, cmd_data, cmd_last, rsp_ready,
        input  cmd_ready, rsp_valid, rsp_data, rsp_last
    );
endinterface
`default_nettype wire

// *** rtl/vfac_device.sv ***
// device end: interprets vf allocation and pass-through queries
//
// Behaviour
// - report supported pass-through paths, bits 0-2
// - query request 0x35, package wide, no payload
// - good query answered with 0xB5
// - query reports advertised vf count per function
// - one count byte per function, ascending order
// - set request 0x36 configures advertised counts
// - sum of requested counts within total limit
// - set counts pending until next pcie reset
// - allocation persists until replaced
// - set payload: count byte per function ascending
// - good set answered 0xB6, codes only
// - report currently allowed paths, same bit positions
`timescale 1ns/1ps
`default_nettype none
module vfac_device #(
    parameter int          NUM_PF    = vfac_pkg::NUM_PF_DEF,
    parameter logic [7:0]  VF_RESET  = vfac_pkg::VF_RESET_DEF
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    vfac_if.dev                          link,
    input  wire logic [vfac_pkg::PT_W-1:0] pt_supported,
    input  wire logic [vfac_pkg::PT_W-1:0] pt_allowed,
    input  wire logic [15:0]             total_vf_limit,
    input  wire logic                    pcie_reset,
    input  wire logic                    cfg_load,
    input  wire logic [NUM_PF*8-1:0]     cfg_counts,
    output logic      [NUM_PF*8-1:0]     advertised_counts,
    output logic      [NUM_PF*8-1:0]     pending_counts,
    output logic                         pending_valid,
    output logic                         set_accepted,
    output logic                         set_rejected
);
    import vfac_pkg::*;

    typedef enum logic [2:0] {
        VFAC_IDLE = 3'b000,
        VFAC_RECV = 3'b001,
        VFAC_EVAL = 3'b010,
        VFAC_LOAD = 3'b011,
        VFAC_SEND = 3'b100
    } vfac_dev_state_e;

    vfac_dev_state_e state;
    logic [7:0]  opc;
    logic [7:0]  rx_cnt;
    logic        rx_ovf;
    logic [7:0]  rx_buf [NUM_PF];
    logic [7:0]  adv    [NUM_PF];
    logic [7:0]  pend   [NUM_PF];
    logic [7:0]  tx_type;
    logic [15:0] tx_code;
    logic [15:0] tx_reason;
    logic [7:0]  tx_len;
    logic [7:0]  tx_idx;
    logic [7:0]  rsp_data;
    logic        rsp_last;

    ////////////////////////////////////////////////////////////////////////
    // request evaluation
    wire         beat      = link.cmd_valid && link.cmd_ready;
    wire  [7:0]  pf_count  = 8'(NUM_PF);
    logic [15:0] req_sum;

    always_comb begin
        req_sum = 16'h0000;
        for (int i = 0; i < NUM_PF; i++) begin
            req_sum = req_sum + {8'h00, rx_buf[i]};
        end
    end

    wire is_query  = (opc == CMD_QUERY_VF);
    wire is_set    = (opc == CMD_SET_VF);
    wire is_pt     = (opc == CMD_GET_PT);
    wire len_zero  = (rx_cnt == 8'h00);
    wire set_len   = (rx_cnt == pf_count) && !rx_ovf;
    wire sum_ok    = (req_sum <= total_vf_limit);
    wire eval_now  = (state == VFAC_EVAL);
    wire set_ok    = eval_now && is_set && set_len && sum_ok;
    wire set_bad   = eval_now && is_set && !(set_len && sum_ok);

    // response fields chosen by command and outcome
    wire         good_q   = is_query && len_zero;
    wire         good_pt  = is_pt && len_zero;
    wire         good_s   = is_set && set_len && sum_ok;
    wire         known    = is_query || is_set || is_pt;
    wire  [7:0]  next_type = is_query ? RSP_QUERY_VF :
                             is_set   ? RSP_SET_VF   :
                             is_pt    ? RSP_GET_PT   : (opc | RSP_FLAG);
    wire  [15:0] next_code = !known                    ? CODE_UNSUPP :
                             (good_q || good_pt || good_s) ? CODE_OK : CODE_FAIL;
    wire  [15:0] next_reason = !known                  ? REASON_CMD  :
                               (good_q || good_pt || good_s) ? REASON_NONE :
                               (is_set && set_len)     ? REASON_PARAM : REASON_LEN;
    // only a successful query or pass-through read carries data bytes
    wire  [7:0]  next_len  = good_q  ? RSP_HDR_LEN + pf_count :
                             good_pt ? RSP_HDR_LEN + PT_DATA_LEN :
                                       RSP_HDR_LEN;

    ////////////////////////////////////////////////////////////////////////
    // response byte selection
    wire  [7:0]  data_idx  = tx_idx - RSP_HDR_LEN;
    wire  [7:0]  pt_cap_b  = {PT_RSVD, pt_supported};
    wire  [7:0]  pt_sta_b  = {PT_RSVD, pt_allowed};
    logic [7:0]  cur_byte;

    always_comb begin
        cur_byte = 8'h00;
        case (tx_idx)
            8'h00:   cur_byte = tx_type;
            8'h01:   cur_byte = tx_code[15:8];
            8'h02:   cur_byte = tx_code[7:0];
            8'h03:   cur_byte = tx_reason[15:8];
            8'h04:   cur_byte = tx_reason[7:0];
            default: begin
                if (tx_type == RSP_GET_PT) begin
                    if (tx_idx == PT_STATUS_IDX) begin
                        cur_byte = pt_sta_b;
                    end else if (tx_idx == PT_CAP_IDX) begin
                        cur_byte = pt_cap_b;
                    end
                end else begin
                    // function 0 first, so word bytes go out lsb first
                    for (int i = 0; i < NUM_PF; i++) begin
                        if (data_idx == 8'(i)) begin
                            cur_byte = adv[i];
                        end
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // link state machine
    assign link.cmd_ready = (state == VFAC_IDLE) || (state == VFAC_RECV);
    assign link.rsp_valid = (state == VFAC_SEND);
    assign link.rsp_data  = rsp_data;
    assign link.rsp_last  = rsp_last;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= VFAC_IDLE;
            opc       <= 8'h00;
            rx_cnt    <= 8'h00;
            rx_ovf    <= 1'b0;
            tx_type   <= 8'h00;
            tx_code   <= 16'h0000;
            tx_reason <= 16'h0000;
            tx_len    <= 8'h00;
            tx_idx    <= 8'h00;
            rsp_data  <= 8'h00;
            rsp_last  <= 1'b0;
        end else begin
            case (state)
                VFAC_IDLE: begin
                    if (beat) begin
                        opc    <= link.cmd_data;
                        rx_cnt <= 8'h00;
                        rx_ovf <= 1'b0;
                        state  <= link.cmd_last ? VFAC_EVAL : VFAC_RECV;
                    end
                end
                VFAC_RECV: begin
                    if (beat) begin
                        // extra bytes are counted as overflow, never stored
                        if (rx_cnt < pf_count) begin
                            rx_cnt <= rx_cnt + 8'h01;
                        end else begin
                            rx_ovf <= 1'b1;
                        end
                        if (link.cmd_last) begin
                            state <= VFAC_EVAL;
                        end
                    end
                end
                VFAC_EVAL: begin
                    tx_type   <= next_type;
                    tx_code   <= next_code;
                    tx_reason <= next_reason;
                    tx_len    <= next_len;
                    tx_idx    <= 8'h00;
                    state     <= VFAC_LOAD;
                end
                VFAC_LOAD: begin
                    rsp_data <= cur_byte;
                    rsp_last <= (tx_len == 8'h01);
                    tx_idx   <= 8'h01;
                    state    <= VFAC_SEND;
                end
                VFAC_SEND: begin
                    if (link.rsp_ready) begin
                        if (rsp_last) begin
                            rsp_last <= 1'b0;
                            state    <= VFAC_IDLE;
                        end else begin
                            rsp_data <= cur_byte;
                            rsp_last <= (tx_idx == tx_len - 8'h01);
                            tx_idx   <= tx_idx + 8'h01;
                        end
                    end
                end
                default: state <= VFAC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < NUM_PF; i++) begin
                rx_buf[i] <= 8'h00;
            end
        end else if (state == VFAC_RECV && beat && rx_cnt < pf_count) begin
            for (int i = 0; i < NUM_PF; i++) begin
                if (rx_cnt == 8'(i)) begin
                    rx_buf[i] <= link.cmd_data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending and advertised allocation
    // a set in the same cycle as a pcie reset stays pending for the next one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pending_valid <= 1'b0;
            set_accepted  <= 1'b0;
            set_rejected  <= 1'b0;
            for (int i = 0; i < NUM_PF; i++) begin
                adv[i]  <= VF_RESET;
                pend[i] <= VF_RESET;
            end
        end else begin
            set_accepted <= set_ok;
            set_rejected <= set_bad;
            if (pcie_reset && pending_valid) begin
                for (int i = 0; i < NUM_PF; i++) begin
                    adv[i] <= pend[i];
                end
            end
            if (set_ok) begin
                for (int i = 0; i < NUM_PF; i++) begin
                    pend[i] <= rx_buf[i];
                end
                pending_valid <= 1'b1;
            end else if (cfg_load) begin
                for (int i = 0; i < NUM_PF; i++) begin
                    pend[i] <= cfg_counts[i*8 +: 8];
                end
                pending_valid <= 1'b1;
            end else if (pcie_reset) begin
                pending_valid <= 1'b0;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PF; i++) begin
            advertised_counts[i*8 +: 8] = adv[i];
            pending_counts[i*8 +: 8]    = pend[i];
        end
    end
endmodule
`default_nettype wire

// *** rtl/vfac_host.sv ***
// management controller end: issues requests and collects responses
`timescale 1ns/1ps
`default_nettype none
module vfac_host #(
    parameter int NUM_PF = vfac_pkg::NUM_PF_DEF
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    vfac_if.mc                           link,
    input  wire logic                    req_query,
    input  wire logic                    req_set,
    input  wire logic                    req_pt,
    input  wire logic [NUM_PF*8-1:0]     set_counts,
    input  wire logic [15:0]             total_vf_limit,
    output logic                         busy,
    output logic                         done,
    output logic                         refused,
    output logic      [7:0]              rsp_type,
    output logic      [15:0]             rsp_code,
    output logic      [15:0]             rsp_reason,
    output logic      [NUM_PF*8-1:0]     got_counts,
    output logic      [vfac_pkg::PT_W-1:0] got_pt_allowed,
    output logic      [vfac_pkg::PT_W-1:0] got_pt_supported
);
    import vfac_pkg::*;

    typedef enum logic [1:0] {
        VFAC_H_IDLE = 2'b00,
        VFAC_H_SEND = 2'b01,
        VFAC_H_RECV = 2'b10
    } vfac_host_state_e;

    vfac_host_state_e state;
    logic [7:0]  cmd_data;
    logic        cmd_last;
    logic [7:0]  tx_idx;
    logic [7:0]  tx_len;
    logic [7:0]  rx_idx;
    logic [7:0]  set_arr [NUM_PF];
    logic [7:0]  got_arr [NUM_PF];
    logic [15:0] set_sum;
    logic [7:0]  tx_byte;

    wire  [7:0]  pf_count = 8'(NUM_PF);
    wire         tx_beat  = link.cmd_valid && link.cmd_ready;
    wire         rx_beat  = link.rsp_valid && link.rsp_ready;
    wire  [7:0]  tx_sel   = tx_idx - 8'h01;
    wire  [7:0]  data_idx = rx_idx - RSP_HDR_LEN;
    // the sum is checked against this end's limit before sending; a set over it is refused, not sent
    wire         set_go   = req_set && (set_sum <= total_vf_limit);

    always_comb begin
        set_sum = 16'h0000;
        tx_byte = 8'h00;
        for (int i = 0; i < NUM_PF; i++) begin
            set_sum = set_sum + {8'h00, set_arr[i]};
            if (tx_sel == 8'(i)) begin
                tx_byte = set_arr[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PF; i++) begin
            set_arr[i]              = set_counts[i*8 +: 8];
            got_counts[i*8 +: 8]    = got_arr[i];
        end
    end

    assign link.cmd_valid = (state == VFAC_H_SEND);
    assign link.cmd_data  = cmd_data;
    assign link.cmd_last  = cmd_last;
    assign link.rsp_ready = (state == VFAC_H_RECV);
    assign busy           = (state != VFAC_H_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // request and response sequencing
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state            <= VFAC_H_IDLE;
            cmd_data         <= 8'h00;
            cmd_last         <= 1'b0;
            tx_idx           <= 8'h00;
            tx_len           <= 8'h00;
            rx_idx           <= 8'h00;
            done             <= 1'b0;
            refused          <= 1'b0;
            rsp_type         <= 8'h00;
            rsp_code         <= 16'h0000;
            rsp_reason       <= 16'h0000;
            got_pt_allowed   <= '0;
            got_pt_supported <= '0;
            for (int i = 0; i < NUM_PF; i++) begin
                got_arr[i] <= 8'h00;
            end
        end else begin
            done    <= 1'b0;
            refused <= 1'b0;
            case (state)
                VFAC_H_IDLE: begin
                    tx_idx <= 8'h01;
                    if (req_query) begin
                        cmd_data <= CMD_QUERY_VF;
                        cmd_last <= 1'b1;
                        tx_len   <= 8'h01;
                        state    <= VFAC_H_SEND;
                    end else if (set_go) begin
                        cmd_data <= CMD_SET_VF;
                        cmd_last <= 1'b0;
                        tx_len   <= pf_count + 8'h01;
                        state    <= VFAC_H_SEND;
                    end else if (req_set) begin
                        refused  <= 1'b1;
                    end else if (req_pt) begin
                        cmd_data <= CMD_GET_PT;
                        cmd_last <= 1'b1;
                        tx_len   <= 8'h01;
                        state    <= VFAC_H_SEND;
                    end
                end
                VFAC_H_SEND: begin
                    if (tx_beat) begin
                        if (cmd_last) begin
                            cmd_last <= 1'b0;
                            rx_idx   <= 8'h00;
                            state    <= VFAC_H_RECV;
                        end else begin
                            cmd_data <= tx_byte;
                            cmd_last <= (tx_idx == tx_len - 8'h01);
                            tx_idx   <= tx_idx + 8'h01;
                        end
                    end
                end
                VFAC_H_RECV: begin
                    if (rx_beat) begin
                        if (rx_idx != 8'hFF) begin
                            rx_idx <= rx_idx + 8'h01;
                        end
                        case (rx_idx)
                            8'h00:   rsp_type          <= link.rsp_data;
                            8'h01:   rsp_code[15:8]    <= link.rsp_data;
                            8'h02:   rsp_code[7:0]     <= link.rsp_data;
                            8'h03:   rsp_reason[15:8]  <= link.rsp_data;
                            8'h04:   rsp_reason[7:0]   <= link.rsp_data;
                            default: begin
                                if (rsp_type == RSP_GET_PT) begin
                                    if (rx_idx == PT_STATUS_IDX) begin
                                        got_pt_allowed <= link.rsp_data[PT_W-1:0];
                                    end
                                    if (rx_idx == PT_CAP_IDX) begin
                                        got_pt_supported <= link.rsp_data[PT_W-1:0];
                                    end
                                end else if (rsp_type == RSP_QUERY_VF) begin
                                    for (int i = 0; i < NUM_PF; i++) begin
                                        if (data_idx == 8'(i)) begin
                                            got_arr[i] <= link.rsp_data;
                                        end
                                    end
                                end
                            end
                        endcase
                        if (link.rsp_last) begin
                            done  <= 1'b1;
                            state <= VFAC_H_IDLE;
                        end
                    end
                end
                default: state <= VFAC_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** test/vfac_props.sv ***
// concurrent checks on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module vfac_props
    import vfac_pkg::*;
#(
    parameter int NUM_PF = 4
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [7:0] cmd_data,
    input wire logic       cmd_last,
    input wire logic       rsp_valid,
    input wire logic       rsp_ready,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_last
);
    localparam int QLAST = NUM_PF + 4;
    logic       cmd_first;
    logic       rsp_first;
    logic [7:0] cur_cmd;
    wire logic       cmd_take = cmd_valid && cmd_ready;
    wire logic       rsp_take = rsp_valid && rsp_ready;
    wire logic       rsp_head = rsp_take && rsp_first;
    // code of the request in flight, visible on its own first byte too
    wire logic [7:0] next_cmd = (cmd_take && cmd_first) ? cmd_data : cur_cmd;
    wire logic       req_end  = cmd_take && cmd_last;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_first <= 1'b1;
            rsp_first <= 1'b1;
            cur_cmd   <= 8'h00;
        end else begin
            if (cmd_take) cmd_first <= cmd_last;
            if (rsp_take) rsp_first <= rsp_last;
            cur_cmd <= next_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_query_no_payload: assert property (
        cmd_take && cmd_first && cmd_data == CMD_QUERY_VF |-> cmd_last)
        else $error("query request carries payload");
    a_answer_delay: assert property (
        req_end |=> (!rsp_valid)[*2] ##1 rsp_valid)
        else $error("response start not three cycles after request");
    a_query_type: assert property (
        req_end && next_cmd == CMD_QUERY_VF |-> ##3 rsp_data == RSP_QUERY_VF)
        else $error("query answered with wrong type");
    a_set_type: assert property (
        req_end && next_cmd == CMD_SET_VF |-> ##3 rsp_data == RSP_SET_VF)
        else $error("set answered with wrong type");
    a_query_codes_ok: assert property (
        rsp_head && rsp_data == RSP_QUERY_VF |=> (rsp_take && rsp_data == 8'h00)[*4])
        else $error("query response codes not zero");
    a_query_len: assert property (
        rsp_head && rsp_data == RSP_QUERY_VF |-> !rsp_last ##QLAST rsp_take && rsp_last)
        else $error("query response length wrong");
    a_set_hdr_only: assert property (
        rsp_head && rsp_data == RSP_SET_VF |-> (!rsp_last)[*4] ##1 rsp_take && rsp_last)
        else $error("set response not header only");
    a_pt_rsvd_zero: assert property (
        rsp_head && rsp_data == RSP_GET_PT |-> ##7 rsp_data[7:3] == PT_RSVD
        ##1 rsp_data[7:3] == PT_RSVD && rsp_last)
        else $error("pass-through upper bits not zero");
endmodule
`default_nettype wire

// *** test/vfac_tb.sv ***
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
module vfac_tb;
    import vfac_pkg::*;
    logic        clk_sys  = 1'b0;
    logic        rst      = 1'b1;
    logic [2:0]  pt_sup   = 3'h0;
    logic [2:0]  pt_alw   = 3'h0;
    logic [15:0] dev_lim  = 16'h000A;
    logic [15:0] host_lim = 16'hFFFF;
    logic        pcie_rst = 1'b0;
    logic        cfg_load = 1'b0;
    logic [31:0] cfg_cnt  = 32'h00000102;
    logic        req_q    = 1'b0;
    logic        req_s    = 1'b0;
    logic        req_p    = 1'b0;
    logic [31:0] set_cnt  = 32'h0;
    logic [31:0] adv, pend, got_cnt;
    logic        pend_v, set_acc, set_rej, busy, done, refused;
    logic [7:0]  rsp_type;
    logic [15:0] rsp_code, rsp_reason;
    logic [2:0]  got_alw, got_sup;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          n_acc     = 0;
    int          n_rej     = 0;
    vfac_if lnk();
    vfac_device #(.NUM_PF(4), .VF_RESET(8'h00)) i_vfac_device (.clk_sys(clk_sys), .rst(rst),
        .link(lnk.dev), .pt_supported(pt_sup), .pt_allowed(pt_alw), .total_vf_limit(dev_lim),
        .pcie_reset(pcie_rst), .cfg_load(cfg_load), .cfg_counts(cfg_cnt), .advertised_counts(adv),
        .pending_counts(pend), .pending_valid(pend_v), .set_accepted(set_acc), .set_rejected(set_rej));
    vfac_host #(.NUM_PF(4)) i_vfac_host (.clk_sys(clk_sys), .rst(rst), .link(lnk.mc),
        .req_query(req_q), .req_set(req_s), .req_pt(req_p), .set_counts(set_cnt),
        .total_vf_limit(host_lim), .busy(busy), .done(done), .refused(refused),
        .rsp_type(rsp_type), .rsp_code(rsp_code), .rsp_reason(rsp_reason), .got_counts(got_cnt),
        .got_pt_allowed(got_alw), .got_pt_supported(got_sup));
    vfac_props #(.NUM_PF(4)) i_vfac_props (.clk_sys(clk_sys), .rst(rst),
        .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready), .cmd_data(lnk.cmd_data),
        .cmd_last(lnk.cmd_last), .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready),
        .rsp_data(lnk.rsp_data), .rsp_last(lnk.rsp_last));

    ////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        if (set_acc === 1'b1) n_acc++;
        if (set_rej === 1'b1) n_rej++;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        @(negedge clk_sys);
    endtask
    // one request, waits for done or refusal; flags still high on return
    task automatic run(input logic q, input logic s, input logic p);
        int n;
        n = 0;
        @(negedge clk_sys);
        {req_q, req_s, req_p} = {q, s, p};
        @(negedge clk_sys);
        {req_q, req_s, req_p} = 3'h0;
        while (done !== 1'b1 && refused !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk(32'(n < 100), 32'h1);
        chk(32'(busy), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_pt();
        for (int i = 0; i < 8; i++) begin
            pt_sup = 3'(i);
            pt_alw = 3'(7 - i);
            run(1'b0, 1'b0, 1'b1);
            chk(32'(got_sup), 32'(i));
            chk(32'(got_alw), 32'(7 - i));
            chk(32'(rsp_type), 32'(RSP_GET_PT));
            chk({rsp_code, rsp_reason}, {CODE_OK, REASON_NONE});
        end
    endtask
    task automatic t_query(input logic [31:0] exp);
        run(1'b1, 1'b0, 1'b0);
        chk(32'(rsp_type), 32'(RSP_QUERY_VF));
        chk({rsp_code, rsp_reason}, {CODE_OK, REASON_NONE});
        chk(got_cnt, exp);
    endtask
    task automatic t_set(input logic [31:0] cnt, input logic [31:0] exp);
        set_cnt = cnt;
        run(1'b0, 1'b1, 1'b0);
        chk(32'(rsp_type), 32'(RSP_SET_VF));
        chk({rsp_code, rsp_reason}, exp);
    endtask

    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        t_pt();
        t_query(32'h0);
        // sum equal to the limit is still legal
        t_set(32'h04030201, {CODE_OK, REASON_NONE});
        chk(pend, 32'h04030201);
        chk(adv, 32'h0);
        t_query(32'h0);
        pulse(pcie_rst);
        chk(32'(pend_v), 32'h0);
        t_query(32'h04030201);
        t_set(32'h05030201, {CODE_FAIL, REASON_PARAM});
        chk(32'(pend_v), 32'h0);
        pulse(pcie_rst);
        t_query(32'h04030201);
        host_lim = 16'h0005;
        set_cnt = 32'h00000006;
        run(1'b0, 1'b1, 1'b0);
        chk(32'(refused), 32'h1);
        host_lim = 16'hFFFF;
        pulse(cfg_load);
        pulse(pcie_rst);
        t_query(32'h00000102);
        chk(32'(n_acc), 32'h1);
        chk(32'(n_rej), 32'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
